// ===== include/frame_check_consts.vh
// Purpose: register offsets, field positions, reset values and codes for the checker and test modes
// Assumes: 16-bit register words on a plain address/strobe port
// Notes: guarded against double inclusion
`ifndef FRAME_CHECK_CONSTS_VH
`define FRAME_CHECK_CONSTS_VH
`define ADR_NEG_CTRL 16'h0200
`define ADR_TEST_MODE 16'h08f8
`define ADR_FORCED 16'h8000
`define ADR_CHK_EN 16'h8001
`define ADR_CHK_SRC 16'h8005
`define ADR_CRC_ERR 16'h8008
`define ADR_FRM_HI 16'h8009
`define ADR_FRM_LO 16'h800a
`define ADR_LEN_ERR 16'h8020
`define ADR_ALN_ERR 16'h8021
`define ADR_SYM_ERR 16'h8022
`define ADR_OVR_ERR 16'h8023
`define ADR_UND_ERR 16'h8024
`define ADR_ODD_FRM 16'h8025
`define ADR_ODD_PRE 16'h8026
`define ADR_FALSE_CAR 16'h8027
`define ADR_PD_CTRL 16'h8812
`define ADR_PD_STAT 16'h8818
`define ADR_IRQ_STAT 16'h8830
`define ADR_IRQ_MASK 16'h8831
`define BIT_CHK_EN 0
`define BIT_CHK_SRC 0
`define BIT_NEG_EN 12
`define BIT_FORCED 0
`define BIT_PD 0
`define BIT_PD_RDY 1
`define RST_NEG_CTRL 16'h1000
`define RST_PD_CTRL 16'h0000
`define PD_SETTLE_CYC 4'h8
`define TM_NORMAL 3'h0
`define TM_ALT 3'h1
`define TM_DROOP 3'h2
`define TM_IDLE 3'h3
`define DROOP_HALF 5'h0a
`define SYM_ZERO 2'h0
`define SYM_PLUS 2'h1
`define SYM_MINUS 2'h3
`define IRQ_BITS 3
`endif

// ===== core/frame_check_and_test_modes.v
// Purpose: frame checker counters with read snapshot, and transmit test pattern generator
// Assumes: frame status strobes arrive from logic on core_clk; pattern symbols replace tx data
// Notes: one clock, asynchronous active-low reset, read data one cycle after read strobe
//
// Behaviour
// - checker counts only while enable bit set
// - source select picks mac or phy frames
// - count crc failures per checked frame
// - crc counter read snapshots all counters
// - frame count split high and low
// - separate length, align, symbol, size counters
// - count odd-nibble bodies and preambles separately
// - count every cycle spent in invalid start state
// - test mode changes only tx symbols and, in mode 3, force_master
// - mode 1 sends plus then minus
// - mode 2 sends ten plus, ten minus
// - mode 3 sends normal idle as master
// - ready bit reports power-down completion
`timescale 1ns/1ps
`include "frame_check_consts.vh"
module frame_check_and_test_modes
(
	// clock and reset
	input wire core_clk,
	input wire arst_n,
	// register port
	input wire [15:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	// frame status from mac side, one-cycle pulses at frame end
	input wire mac_frame_done,
	input wire [7:0] mac_frame_flags,
	input wire mac_invalid_stream_start_state,
	// frame status from phy receive path
	input wire phy_frame_done,
	input wire [7:0] phy_frame_flags,
	input wire phy_invalid_stream_start_state,
	// transmit symbol path
	input wire [1:0] tx_sym_in,
	input wire tx_sym_valid,
	output reg [1:0] tx_sym_out,
	output reg tx_sym_out_valid,
	output reg force_master,
	// control outputs
	output reg negotiation_enable,
	output reg negotiation_forced_mode,
	output reg software_powerdown,
	output reg irq
);
	// flag bits: 0 crc,1 len,2 align,3 symbol,4 oversize,5 undersize,6 odd body,7 odd preamble
	localparam N_ERR = 8;
	localparam [15:0] NEG_RST = `RST_NEG_CTRL;

	// registers
	reg checker_enable_r;
	reg checker_source_select_r;
	reg [2:0] tx_test_mode_control_r;
	reg [31:0] frame_cnt_r;
	reg [31:0] frame_latch_r;
	reg [15:0] false_car_r;
	reg [15:0] false_car_latch_r;
	reg [15:0] err_cnt_r [0:N_ERR-1];
	reg [15:0] err_latch_r [0:N_ERR-1];
	reg [3:0] pd_cnt_r;
	reg pd_rdy_r;
	reg [2:0] irq_stat_r;
	reg [2:0] irq_mask_r;
	reg [4:0] sym_cnt_r;
	reg sym_phase_r;

	// selected source
	wire sel_done = checker_source_select_r ? phy_frame_done : mac_frame_done;
	wire [7:0] sel_flags = checker_source_select_r ? phy_frame_flags : mac_frame_flags;
	wire sel_ssd = checker_source_select_r ? phy_invalid_stream_start_state : mac_invalid_stream_start_state;
	wire frame_ev = checker_enable_r & sel_done;
	wire ssd_ev = checker_enable_r & sel_ssd;
	wire snap = reg_rd & (reg_addr == `ADR_CRC_ERR);
	wire stat_rd = reg_rd & (reg_addr == `ADR_IRQ_STAT);

	// saturating increment keeps a full counter from wrapping to zero
	function [15:0] inc16;
		input [15:0] v;
		input en;
		begin
			inc16 = (en && v != 16'hffff) ? v + 16'h0001 : v;
		end
	endfunction

	// the two pattern modes that replace the transmit stream
	function is_pattern;
		input [2:0] m;
		begin
			is_pattern = (m == `TM_ALT) || (m == `TM_DROOP);
		end
	endfunction

	// config register writes
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			checker_enable_r <= 1'b0;
			checker_source_select_r <= 1'b0;
			tx_test_mode_control_r <= `TM_NORMAL;
			negotiation_enable <= NEG_RST[`BIT_NEG_EN];
			negotiation_forced_mode <= 1'b0;
			software_powerdown <= 1'b0;
			irq_mask_r <= 3'h0;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`ADR_CHK_EN:
				begin
					checker_enable_r <= reg_wdata[`BIT_CHK_EN];
				end
				`ADR_CHK_SRC:
				begin
					checker_source_select_r <= reg_wdata[`BIT_CHK_SRC];
				end
				`ADR_TEST_MODE:
				begin
					tx_test_mode_control_r <= reg_wdata[2:0];
				end
				`ADR_NEG_CTRL:
				begin
					negotiation_enable <= reg_wdata[`BIT_NEG_EN];
				end
				`ADR_FORCED:
				begin
					negotiation_forced_mode <= reg_wdata[`BIT_FORCED];
				end
				`ADR_PD_CTRL:
				begin
					software_powerdown <= reg_wdata[`BIT_PD];
				end
				`ADR_IRQ_MASK:
				begin
					irq_mask_r <= reg_wdata[2:0];
				end
				default: ;
			endcase
		end
	end

	// frame and false carrier counters with snapshot
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			frame_cnt_r <= 32'h00000000;
			frame_latch_r <= 32'h00000000;
			false_car_r <= 16'h0000;
			false_car_latch_r <= 16'h0000;
		end
		else
		begin
			if (frame_ev && frame_cnt_r != 32'hffffffff)
				frame_cnt_r <= frame_cnt_r + 32'h00000001;
			false_car_r <= inc16(false_car_r, ssd_ev);
			if (snap)
			begin
				frame_latch_r <= frame_cnt_r;
				false_car_latch_r <= false_car_r;
			end
		end
	end

	// per-class error counters, one per flag bit
	genvar gi;
	generate
		for (gi = 0; gi < N_ERR; gi = gi + 1)
		begin : g_err
			always @(posedge core_clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					err_cnt_r[gi] <= 16'h0000;
					err_latch_r[gi] <= 16'h0000;
				end
				else
				begin
					err_cnt_r[gi] <= inc16(err_cnt_r[gi], frame_ev & sel_flags[gi]);
					if (snap)
						err_latch_r[gi] <= err_cnt_r[gi];
				end
			end
		end
	endgenerate

	// power-down ready after a short settle; cleared as soon as power-down drops
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pd_cnt_r <= 4'h0;
			pd_rdy_r <= 1'b0;
		end
		else if (!software_powerdown)
		begin
			pd_cnt_r <= 4'h0;
			pd_rdy_r <= 1'b0;
		end
		else if (pd_cnt_r != `PD_SETTLE_CYC)
			pd_cnt_r <= pd_cnt_r + 4'h1;
		else
			pd_rdy_r <= 1'b1;
	end

	// sticky events: 0 crc error, 1 false carrier, 2 power-down ready; set beats read-clear
	// ready event taken on the rising edge of the ready flag
	wire pd_rise = software_powerdown & ~pd_rdy_r & (pd_cnt_r == `PD_SETTLE_CYC);
	wire [2:0] irq_ev_q = {pd_rise, ssd_ev, frame_ev & sel_flags[0]};
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irq_stat_r <= 3'h0;
			irq <= 1'b0;
		end
		else
		begin
			irq_stat_r <= (stat_rd ? 3'h0 : irq_stat_r) | irq_ev_q;
			irq <= |(((stat_rd ? 3'h0 : irq_stat_r) | irq_ev_q) & irq_mask_r);
		end
	end

	// read mux, data one cycle after the strobe; unmapped reads as zero
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= 16'h0000;
		else if (reg_rd)
		begin
			case (reg_addr)
				`ADR_NEG_CTRL:
				begin
					reg_rdata <= {3'h0, negotiation_enable, 12'h000};
				end
				`ADR_TEST_MODE:
				begin
					reg_rdata <= {13'h0000, tx_test_mode_control_r};
				end
				`ADR_FORCED:
				begin
					reg_rdata <= {15'h0000, negotiation_forced_mode};
				end
				`ADR_CHK_EN:
				begin
					reg_rdata <= {15'h0000, checker_enable_r};
				end
				`ADR_CHK_SRC:
				begin
					reg_rdata <= {15'h0000, checker_source_select_r};
				end
				`ADR_CRC_ERR:
				begin
					reg_rdata <= err_cnt_r[0];
				end
				`ADR_FRM_HI:
				begin
					reg_rdata <= frame_latch_r[31:16];
				end
				`ADR_FRM_LO:
				begin
					reg_rdata <= frame_latch_r[15:0];
				end
				`ADR_LEN_ERR:
				begin
					reg_rdata <= err_latch_r[1];
				end
				`ADR_ALN_ERR:
				begin
					reg_rdata <= err_latch_r[2];
				end
				`ADR_SYM_ERR:
				begin
					reg_rdata <= err_latch_r[3];
				end
				`ADR_OVR_ERR:
				begin
					reg_rdata <= err_latch_r[4];
				end
				`ADR_UND_ERR:
				begin
					reg_rdata <= err_latch_r[5];
				end
				`ADR_ODD_FRM:
				begin
					reg_rdata <= err_latch_r[6];
				end
				`ADR_ODD_PRE:
				begin
					reg_rdata <= err_latch_r[7];
				end
				`ADR_FALSE_CAR:
				begin
					reg_rdata <= false_car_latch_r;
				end
				`ADR_PD_CTRL:
				begin
					reg_rdata <= {15'h0000, software_powerdown};
				end
				`ADR_PD_STAT:
				begin
					reg_rdata <= {14'h0000, pd_rdy_r, 1'b0};
				end
				`ADR_IRQ_STAT:
				begin
					reg_rdata <= {13'h0000, irq_stat_r};
				end
				`ADR_IRQ_MASK:
				begin
					reg_rdata <= {13'h0000, irq_mask_r};
				end
				default: reg_rdata <= 16'h0000;
			endcase
		end
	end

	// pattern sequencer: phase flips every symbol (mode 1) or every ten (mode 2)
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sym_cnt_r <= 5'h00;
			sym_phase_r <= 1'b0;
		end
		else if (software_powerdown || tx_test_mode_control_r == `TM_NORMAL)
		begin
			sym_cnt_r <= 5'h00;
			sym_phase_r <= 1'b0;
		end
		else if (tx_test_mode_control_r == `TM_ALT)
			sym_phase_r <= ~sym_phase_r;
		else if (tx_test_mode_control_r == `TM_DROOP)
		begin
			if (sym_cnt_r == `DROOP_HALF - 5'h01)
			begin
				sym_cnt_r <= 5'h00;
				sym_phase_r <= ~sym_phase_r;
			end
			else
				sym_cnt_r <= sym_cnt_r + 5'h01;
		end
	end

	// symbol mux: the tx stream changes, and force_master in mode 3; modes 3 and unknown pass normal data
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_sym_out <= `SYM_ZERO;
			tx_sym_out_valid <= 1'b0;
			force_master <= 1'b0;
		end
		else
		begin
			force_master <= (tx_test_mode_control_r == `TM_IDLE) & ~software_powerdown;
			if (!software_powerdown && is_pattern(tx_test_mode_control_r))
			begin
				tx_sym_out <= sym_phase_r ? `SYM_MINUS : `SYM_PLUS;
				tx_sym_out_valid <= 1'b1;
			end
			else
			begin
				tx_sym_out <= tx_sym_in;
				tx_sym_out_valid <= tx_sym_valid & ~software_powerdown;
			end
		end
	end
endmodule // frame_check_and_test_modes

// ===== tb/frame_check_props.sv
// Purpose: concurrent checks on register writes and the transmit symbol stream
// Assumes: one clock domain; mode field shadowed from register writes
// Notes: mode only changes during power-down, so shadow and design agree
`timescale 1ns/1ps
module frame_check_props
(
	// clock, reset and register writes
	input wire core_clk,
	input wire arst_n,
	input wire [15:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	// transmit path and config outputs
	input wire [1:0] tx_sym_in,
	input wire tx_sym_valid,
	input wire [1:0] tx_sym_out,
	input wire tx_sym_out_valid,
	input wire force_master,
	input wire negotiation_enable,
	input wire software_powerdown
);
	reg [2:0] mode_r;
	reg [15:0] wd_r;
	// last write data, no reset needed since only read after a write
	always @(posedge core_clk)
		wd_r <= reg_wdata;
	// shadow of the test mode field
	always @(posedge core_clk or negedge arst_n)
		if (!arst_n)
			mode_r <= 3'h0;
		else if (reg_wr && reg_addr == 16'h08f8)
			mode_r <= reg_wdata[2:0];
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	a_neg_write_bit: assert property (
		reg_wr && reg_addr == 16'h0200 |=> negotiation_enable == wd_r[12]) else $error("neg bit");
	a_pd_write_bit: assert property (
		reg_wr && reg_addr == 16'h8812 |=> software_powerdown == wd_r[0]) else $error("pd bit");
	a_pd_tx_quiet: assert property (
		software_powerdown |=> !tx_sym_out_valid) else $error("tx during power-down");
	a_alt_plus_next: assert property (
		mode_r == 3'h1 && !software_powerdown && tx_sym_out_valid && tx_sym_out == 2'h1
		|=> tx_sym_out_valid && tx_sym_out == 2'h3) else $error("mode 1 after plus");
	a_alt_minus_next: assert property (
		mode_r == 3'h1 && !software_powerdown && tx_sym_out_valid && tx_sym_out == 2'h3
		|=> tx_sym_out_valid && tx_sym_out == 2'h1) else $error("mode 1 after minus");
	a_normal_pass: assert property (
		((mode_r == 3'h0 || mode_r > 3'h3) && !software_powerdown && tx_sym_valid)[*3]
		|=> tx_sym_out_valid && tx_sym_out == $past(tx_sym_in)) else $error("normal path");
	a_idle_master: assert property (
		(mode_r == 3'h3 && !software_powerdown)[*3] |-> force_master) else $error("no master");
	a_master_only: assert property (
		(mode_r != 3'h3)[*2] |-> !force_master) else $error("stray master");
endmodule // frame_check_props
bind frame_check_and_test_modes frame_check_props u_props (.core_clk(core_clk),
	.arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.tx_sym_in(tx_sym_in), .tx_sym_valid(tx_sym_valid), .tx_sym_out(tx_sym_out),
	.tx_sym_out_valid(tx_sym_out_valid), .force_master(force_master),
	.negotiation_enable(negotiation_enable), .software_powerdown(software_powerdown));

// ===== tb/remote_phy_model.sv
// Purpose: far-side model handing frame end status up the receive path
// Assumes: one status pulse per send request
// Notes: flags are inverted every cycle outside the done cycle, so stale values match only on alternate cycles
`timescale 1ns/1ps
module remote_phy_model
(
	// request from bench
	input wire core_clk,
	input wire send,
	input wire [7:0] flags,
	// toward the device
	output reg phy_frame_done = 1'b0,
	output reg [7:0] phy_frame_flags = 8'h00
);
	// registered pulse, flags inverted while idle
	always @(posedge core_clk)
	begin
		phy_frame_done <= send;
		phy_frame_flags <= send ? flags : ~phy_frame_flags;
	end
endmodule // remote_phy_model

// ===== tb/frame_check_and_test_modes_bench.sv
// Purpose: self-checking bench for checker counters, interrupt and tx test modes
// Assumes: 40 MHz clock, read data one cycle after the read strobe
// Notes: a set mask bit lets its status bit reach the interrupt line
`timescale 1ns/1ps
`include "frame_check_consts.vh"
module frame_check_and_test_modes_bench;
	logic core_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, send = 1'b0;
	logic mac_frame_done = 1'b0, mac_invalid_stream_start_state = 1'b0, phy_frame_done, irq, force_master;
	logic tx_sym_out_valid, negotiation_enable, negotiation_forced_mode, software_powerdown;
	logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata, rv;
	logic [7:0] mac_frame_flags = 8'h00, pflags = 8'h00, phy_frame_flags;
	logic [1:0] tx_sym_in = 2'h0, tx_sym_out, e;
	int miscompares = 0, checked = 0, i;
	initial forever #12.5 core_clk = ~core_clk;
	frame_check_and_test_modes DUT (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.mac_frame_done(mac_frame_done), .mac_frame_flags(mac_frame_flags),
		.mac_invalid_stream_start_state(mac_invalid_stream_start_state), .phy_frame_done(phy_frame_done),
		.phy_frame_flags(phy_frame_flags), .phy_invalid_stream_start_state(1'b0), .tx_sym_in(tx_sym_in),
		.tx_sym_valid(1'b1), .tx_sym_out(tx_sym_out), .tx_sym_out_valid(tx_sym_out_valid),
		.force_master(force_master), .negotiation_enable(negotiation_enable),
		.negotiation_forced_mode(negotiation_forced_mode),
		.software_powerdown(software_powerdown), .irq(irq));
	remote_phy_model u_remote (.core_clk(core_clk), .send(send), .flags(pflags),
		.phy_frame_done(phy_frame_done), .phy_frame_flags(phy_frame_flags));
	task summarize;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] x, input logic [15:0] g);
		#1;
		checked++;
		if (g !== x)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, x, g);
		end
	endtask
	task wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [15:0] a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	// one frame end from the mac side or through the remote model
	task fr(input logic src, input logic [7:0] f);
		@(posedge core_clk);
		mac_frame_done <= !src;
		mac_frame_flags <= f;
		send <= src;
		pflags <= f;
		@(posedge core_clk);
		mac_frame_done <= 1'b0;
		mac_frame_flags <= ~f;
		send <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask
	task t_reset;
		chk("reset outs", 16'h0008, {12'h000, negotiation_enable, negotiation_forced_mode,
			software_powerdown, irq});
		rd(`ADR_NEG_CTRL);
		chk("neg ctrl", `RST_NEG_CTRL, rv);
		wr(16'h0100, 16'hffff);
		rd(16'h0100);
		chk("unmapped", 16'h0000, rv);
	endtask
	task t_checker;
		fr(1'b0, 8'h01);
		wr(`ADR_CHK_EN, 16'h0001);
		fr(1'b0, 8'hfe);
		fr(1'b0, 8'h01);
		fr(1'b1, 8'h01);
		repeat (2)
		begin
			@(posedge core_clk);
			mac_invalid_stream_start_state <= 1'b1;
			@(posedge core_clk);
			mac_invalid_stream_start_state <= 1'b0;
		end
		rd(`ADR_CRC_ERR);
		chk("crc count", 16'h0001, rv);
		rd(`ADR_FRM_HI);
		chk("frames hi", 16'h0000, rv);
		fr(1'b0, 8'h00);
		rd(`ADR_FRM_LO);
		chk("frames lo", 16'h0002, rv);
		for (int k = 0; k < 7; k++)
		begin
			rd(`ADR_LEN_ERR + k[15:0]);
			chk("error class", 16'h0001, rv);
		end
		rd(`ADR_FALSE_CAR);
		chk("false carrier", 16'h0002, rv);
		wr(`ADR_CHK_SRC, 16'h0001);
		fr(1'b1, 8'h01);
		fr(1'b0, 8'h01);
		rd(`ADR_CRC_ERR);
		chk("crc phy", 16'h0002, rv);
		rd(`ADR_FRM_LO);
		chk("frames phy", 16'h0004, rv);
	endtask
	task t_irq;
		rd(`ADR_IRQ_STAT);
		wr(`ADR_IRQ_MASK, 16'h0000);
		fr(1'b1, 8'h01);
		chk("irq masked", 16'h0000, {15'h0000, irq});
		wr(`ADR_IRQ_MASK, 16'h0007);
		repeat (2) @(posedge core_clk);
		chk("irq raised", 16'h0001, {15'h0000, irq});
		rd(`ADR_IRQ_STAT);
		chk("irq status", 16'h0001, rv & 16'h0001);
		repeat (2) @(posedge core_clk);
		chk("irq cleared", 16'h0000, {15'h0000, irq});
	endtask
	// software sequence into a test mode, then judge the symbol stream
	task t_mode(input logic [2:0] m, input logic [1:0] s);
		wr(`ADR_PD_CTRL, 16'h0001);
		rv = 16'h0000;
		for (i = 0; i < 40 && rv[1] !== 1'b1; i++)
			rd(`ADR_PD_STAT);
		chk("pd ready", 16'h0002, rv & 16'h0002);
		if (miscompares != 0)
			summarize;
		wr(`ADR_NEG_CTRL, 16'h0000);
		wr(`ADR_FORCED, 16'h0001);
		wr(`ADR_TEST_MODE, {13'h0000, m});
		tx_sym_in <= s;
		wr(`ADR_PD_CTRL, 16'h0000);
		for (i = 0; i < 20 && tx_sym_out_valid !== 1'b1; i++)
			@(negedge core_clk);
		if (i == 20)
		begin
			miscompares++;
			summarize;
		end
		for (i = 0; i < 40; i++)
		begin
			e = (m == 3'h1) ? (i[0] ? 2'h3 : 2'h1) : (m == 3'h2) ? ((i % 20) < 10 ? 2'h1 : 2'h3) : s;
			chk("tx symbol", {13'h0000, 1'b1, e}, {13'h0000, tx_sym_out_valid, tx_sym_out});
			@(negedge core_clk);
		end
		chk("master", {15'h0000, m == 3'h3}, {15'h0000, force_master});
		if (miscompares != 0)
			summarize;
	endtask
	initial
	begin
		repeat (16) @(posedge core_clk);
		arst_n <= 1'b1;
		t_reset;
		t_checker;
		t_irq;
		t_mode(3'h1, 2'h0);
		t_mode(3'h2, 2'h0);
		t_mode(3'h3, 2'h3);
		t_mode(3'h5, 2'h3);
		t_mode(3'h0, 2'h1);
		summarize;
	end
endmodule // frame_check_and_test_modes_bench
